// ===== hdl/cbs_cfg.svh
`ifndef CBS_CFG_SVH
`define CBS_CFG_SVH

// widths
`define CBS_PC_W          13
`define CBS_INSTR_W       16
`define CBS_IO_ADDR_W     5

// instruction word layout
`define CBS_OP_MSB        15
`define CBS_OP_LSB        12
`define CBS_K_MSB         9
`define CBS_K_LSB         3
`define CBS_IO_MSB        7
`define CBS_IO_LSB        3
`define CBS_SEL_MSB       2
`define CBS_SEL_LSB       0

// operation codes
`define CBS_OP_OTHER      4'h0
`define CBS_OP_SKIP_IO    4'h1
`define CBS_OP_BSET       4'h2
`define CBS_OP_BCLR       4'h3
`define CBS_OP_EQ         4'h4
`define CBS_OP_NE         4'h5
`define CBS_OP_CS         4'h6
`define CBS_OP_CC         4'h7
`define CBS_OP_SH         4'h8
`define CBS_OP_LO         4'h9
`define CBS_OP_MI         4'ha
`define CBS_OP_PL         4'hb
`define CBS_OP_GE         4'hc
`define CBS_OP_LT         4'hd

// status flag positions
`define CBS_FLAG_C        3'h0
`define CBS_FLAG_Z        3'h1
`define CBS_FLAG_N        3'h2
`define CBS_FLAG_V        3'h3

// reset values and increments
`define CBS_PC_RST        13'h0000
`define CBS_PC_STEP       13'h0001
`define CBS_SKIP_SHORT    13'h0002
`define CBS_SKIP_LONG     13'h0003

// state codes, one hot
`define CBS_ST_IDLE       4'h1
`define CBS_ST_BR2        4'h2
`define CBS_ST_SK2        4'h4
`define CBS_ST_SK3        4'h8

`endif

// ===== hdl/cbs_pkg.sv
`include "cbs_cfg.svh"

package cbs_pkg;

  typedef logic [`CBS_PC_W-1:0] cbs_pc_t;

  typedef enum logic [3:0] {
    CBS_IDLE = `CBS_ST_IDLE,
    CBS_BR2  = `CBS_ST_BR2,
    CBS_SK2  = `CBS_ST_SK2,
    CBS_SK3  = `CBS_ST_SK3
  } cbs_state_e;

  typedef enum logic [3:0] {
    CBS_OTHER                   = `CBS_OP_OTHER,
    CBS_SKIP_IF_IO_BIT_SET      = `CBS_OP_SKIP_IO,
    CBS_BRANCH_STATUS_BIT_SET   = `CBS_OP_BSET,
    CBS_BRANCH_STATUS_BIT_CLEAR = `CBS_OP_BCLR,
    CBS_BRANCH_EQUAL            = `CBS_OP_EQ,
    CBS_BRANCH_NOT_EQUAL        = `CBS_OP_NE,
    CBS_BRANCH_CARRY_SET        = `CBS_OP_CS,
    CBS_BRANCH_CARRY_CLEAR      = `CBS_OP_CC,
    CBS_BRANCH_SAME_OR_HIGHER   = `CBS_OP_SH,
    CBS_BRANCH_LOWER            = `CBS_OP_LO,
    CBS_BRANCH_MINUS            = `CBS_OP_MI,
    CBS_BRANCH_PLUS             = `CBS_OP_PL,
    CBS_BRANCH_SIGNED_GE        = `CBS_OP_GE,
    CBS_BRANCH_SIGNED_LT        = `CBS_OP_LT
  } cbs_cmd_e;

endpackage

// ===== hdl/cbs_unit.sv
// Function
// [RULE1] io bit set skips next, pc+2/3
// [RULE2] status bit s set: pc+k+1
// [RULE3] status bit s clear: pc+k+1
// [RULE4] equal on z=1, not equal on z=0
// [RULE5] carry set/clear branches follow carry flag
// [RULE6] same-or-higher c=0, lower c=1
// [RULE7] minus on n=1, plus on n=0
// [RULE8] flags untouched; branch 1 cycle, taken 2
// [RULE9] signed ge and lt relative branches
// [RULE10] signed test uses n xor v
// [RULE11] k is 7-bit signed, sign-extended
`timescale 1ns/10ps
`include "cbs_cfg.svh"

module cbs_unit
  import cbs_pkg::*;
(
  input  wire logic                       sys_clk,
  input  wire logic                       arst_n,
  input  wire logic                       instr_valid,
  input  wire logic [`CBS_INSTR_W-1:0]    instr_word,
  input  wire logic                       next_is_two_word,
  input  wire logic [7:0]                 core_status_register,
  input  wire logic [7:0]                 io_rdata,
  output logic                            instr_ready,
  output logic [`CBS_IO_ADDR_W-1:0]       io_addr,
  output logic                            status_write_en,
  output logic                            instr_done,
  output logic                            branch_taken,
  output logic [`CBS_PC_W-1:0]            pc
);

  // sequencer state
  cbs_state_e                state;
  cbs_state_e                next_state;
  logic                      next_instr_done;
  logic                      next_branch_taken;

  // program counter state
  cbs_pc_t                   next_pc;
  cbs_pc_t                   target;
  cbs_pc_t                   next_target;

  // instruction fields
  cbs_cmd_e                  cmd;
  logic [2:0]                sel;
  logic [6:0]                k_raw;
  cbs_pc_t                   k_ext;
  logic [7:0]                sel_hot;

  // flags and condition decode
  logic                      flag_c;
  logic                      flag_z;
  logic                      flag_n;
  logic                      flag_v;
  logic                      sel_flag;
  logic                      io_bit;
  logic                      is_branch;
  logic                      cond;

  // take-cycle decisions
  logic                      take;
  logic                      is_skip;
  logic                      skip_hit;
  logic                      branch_hit;
  logic                      in_idle;
  logic                      in_br2;
  logic                      in_sk2;
  logic                      last_step;
  cbs_pc_t                   pc_step;
  cbs_pc_t                   pc_skip;
  cbs_pc_t                   pc_branch;

  // unknown opcodes decode as other and simply step the pc
  assign cmd    = cbs_cmd_e'(instr_word[`CBS_OP_MSB:`CBS_OP_LSB]);
  assign sel    = instr_word[`CBS_SEL_MSB:`CBS_SEL_LSB];
  assign k_raw  = instr_word[`CBS_K_MSB:`CBS_K_LSB];
  assign k_ext  = {{(`CBS_PC_W-7){k_raw[6]}}, k_raw}; // RULE11

  // io address is combinational so the byte is back within the same cycle
  assign io_addr = instr_word[`CBS_IO_MSB:`CBS_IO_LSB];

  // one-hot bit select shared by the io skip and the status-bit branches
  for (genvar i = 0; i < 8; i++) begin : g_sel
    assign sel_hot[i] = (sel == 3'(i));
  end

  assign io_bit   = |(io_rdata & sel_hot); // RULE1
  assign sel_flag = |(core_status_register & sel_hot); // RULE2 RULE3

  assign flag_c   = core_status_register[`CBS_FLAG_C];
  assign flag_z   = core_status_register[`CBS_FLAG_Z];
  assign flag_n   = core_status_register[`CBS_FLAG_N];
  assign flag_v   = core_status_register[`CBS_FLAG_V];

  // flags are only read; the core owns the status register
  assign status_write_en = 1'b0; // RULE8

  // one-hot state decode
  assign in_idle   = (state == CBS_IDLE);
  assign in_br2    = (state == CBS_BR2);
  assign in_sk2    = (state == CBS_SK2);
  assign last_step = in_br2 || in_sk2;

  // new instructions are only accepted between multi-cycle sequences
  assign instr_ready = in_idle;
  assign take        = instr_valid && in_idle;

  // branch condition per opcode; the skip and other codes fall to default
  always_comb begin
    is_branch = 1'b1;
    cond      = 1'b0;
    case (cmd)
      // status-bit branches
      CBS_BRANCH_STATUS_BIT_SET:   cond = sel_flag; // RULE2
      CBS_BRANCH_STATUS_BIT_CLEAR: cond = !sel_flag; // RULE3
      // zero flag
      CBS_BRANCH_EQUAL:            cond = flag_z; // RULE4
      CBS_BRANCH_NOT_EQUAL:        cond = !flag_z; // RULE4
      // carry flag and its unsigned aliases
      CBS_BRANCH_CARRY_SET:        cond = flag_c; // RULE5
      CBS_BRANCH_CARRY_CLEAR:      cond = !flag_c; // RULE5
      CBS_BRANCH_SAME_OR_HIGHER:   cond = !flag_c; // RULE6
      CBS_BRANCH_LOWER:            cond = flag_c; // RULE6
      // negative flag
      CBS_BRANCH_MINUS:            cond = flag_n; // RULE7
      CBS_BRANCH_PLUS:             cond = !flag_n; // RULE7
      // signed compare
      CBS_BRANCH_SIGNED_GE:        cond = !(flag_n ^ flag_v); // RULE9 RULE10
      CBS_BRANCH_SIGNED_LT:        cond = flag_n ^ flag_v; // RULE9 RULE10
      default:                     is_branch = 1'b0;
    endcase
  end

  // is_branch is low for the skip, so the two hits never meet
  assign is_skip    = (cmd == CBS_SKIP_IF_IO_BIT_SET);
  assign skip_hit   = take && is_skip && io_bit; // RULE1
  assign branch_hit = take && is_branch && cond; // RULE8

  // all candidates are formed every cycle; the pc wraps at 8k words, unchecked
  assign pc_step   = pc + `CBS_PC_STEP; // RULE8
  assign pc_skip   = next_is_two_word ? pc + `CBS_SKIP_LONG
                                      : pc + `CBS_SKIP_SHORT; // RULE1
  assign pc_branch = pc + k_ext + `CBS_PC_STEP; // RULE2 RULE3 RULE9

  always_comb begin
    next_state        = state;
    next_instr_done   = 1'b0;
    next_branch_taken = 1'b0;
    case (state)
      CBS_IDLE: begin
        if (skip_hit) begin
          // skipped word count depends on the following instruction
          if (next_is_two_word) begin
            next_state = CBS_SK3; // RULE1
          end else begin
            next_state = CBS_SK2; // RULE1
          end
        end else if (branch_hit) begin
          next_state = CBS_BR2; // RULE8
        // a branch not taken, a clear io bit and other codes finish here
        end else if (take) begin
          next_instr_done = 1'b1; // RULE8
        end
      end
      CBS_SK3: begin
        next_state = CBS_SK2; // RULE1
      end
      CBS_SK2, CBS_BR2: begin
        next_state        = CBS_IDLE;
        next_instr_done   = 1'b1; // RULE1 RULE8
        next_branch_taken = 1'b1;
      end
      default: begin
        next_state = CBS_IDLE;
      end
    endcase
  end

  // target is held from the take edge, so flags may move in the extra cycles
  always_comb begin
    next_pc     = pc;
    next_target = target;
    if (skip_hit) begin
      next_target = pc_skip; // RULE1
    end else if (branch_hit) begin
      next_target = pc_branch; // RULE2 RULE3 RULE9
    end else if (take) begin
      next_pc = pc_step; // RULE8
    end
    // last edge of a taken branch or skip loads the held target
    if (last_step) begin
      next_pc = target; // RULE1 RULE8
    end
  end

  // sequencer registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state        <= CBS_IDLE;
      instr_done   <= 1'b0;
      branch_taken <= 1'b0;
    end else begin
      state        <= next_state;
      instr_done   <= next_instr_done;
      branch_taken <= next_branch_taken;
    end
  end

  // program counter registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc     <= `CBS_PC_RST;
      target <= `CBS_PC_RST;
    end else begin
      pc     <= next_pc;
      target <= next_target;
    end
  end

endmodule

// ===== verification/cbs_io_model.sv
`timescale 1ns/10ps
module cbs_io_model (
  input  wire logic [4:0] io_addr,
  output logic      [7:0] io_rdata
);
  // each register reads back its own address in the low five bits; combinational, as the core samples same cycle
  assign io_rdata = {io_addr[2:0], io_addr};
endmodule

// ===== verification/cbs_unit_sva.sv
`timescale 1ns/10ps
module cbs_unit_sva (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic        next_is_two_word,
  input wire logic [7:0]  core_status_register,
  input wire logic [7:0]  io_rdata,
  input wire logic        instr_ready,
  input wire logic [4:0]  io_addr,
  input wire logic        status_write_en,
  input wire logic        instr_done,
  input wire logic        branch_taken,
  input wire logic [12:0] pc
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire        take = instr_valid && instr_ready;
  wire [3:0]  op   = instr_word[15:12];
  wire [7:0]  f    = core_status_register;
  wire [12:0] kx   = {{6{instr_word[9]}}, instr_word[9:3]};
  sequence s_hold;
    !instr_ready;
  endsequence
  sequence s_fin;
    instr_done && branch_taken;
  endsequence
  AST_FLAGS_KEPT: assert property (!status_write_en)
    else $error("flag write enable raised");
  AST_TAKEN_DONE: assert property (branch_taken |-> instr_done)
    else $error("taken without done");
  AST_IO_ADDR: assert property (io_addr == instr_word[7:3])
    else $error("io address wrong");
  AST_STEP_ONE: assert property (take && op == 4'h0 |=> instr_done && pc == $past(pc) + 13'h1)
    else $error("plain step wrong");
  AST_EQ_TAKEN: assert property (take && op == 4'h4 && f[1] |=> s_hold ##1 (s_fin
    and (pc == $past(pc, 2) + $past(kx, 2) + 13'h1))) else $error("equal branch wrong");
  AST_NE_FALL: assert property (take && op == 4'h5 && f[1] |=> instr_done && !branch_taken)
    else $error("not equal fell wrong");
  AST_LOWER: assert property (take && op == 4'h9 && f[0] |=> s_hold ##1 s_fin)
    else $error("lower branch wrong");
  AST_LT_FALL: assert property (take && op == 4'hd && !(f[2] ^ f[3])
    |=> instr_done && !branch_taken && instr_ready)
    else $error("signed lt wrong");
  AST_SKIP_LONG: assert property (take && op == 4'h1 && io_rdata[instr_word[2:0]]
    && next_is_two_word |=> s_hold[*2] ##1 (s_fin and (pc == $past(pc, 3) + 13'h3)))
    else $error("long skip wrong");
endmodule
bind cbs_unit cbs_unit_sva i_sva (
  .sys_clk              (sys_clk),
  .arst_n               (arst_n),
  .instr_valid          (instr_valid),
  .instr_word           (instr_word),
  .next_is_two_word     (next_is_two_word),
  .core_status_register (core_status_register),
  .io_rdata             (io_rdata),
  .instr_ready          (instr_ready),
  .io_addr              (io_addr),
  .status_write_en      (status_write_en),
  .instr_done           (instr_done),
  .branch_taken         (branch_taken),
  .pc                   (pc)
);

// ===== verification/conditional_branch_skip_unit_test.sv
`timescale 1ns/10ps
module conditional_branch_skip_unit_test;
  logic        sys_clk = 0, arst_n = 0, instr_valid = 0, next_is_two_word = 0;
  logic [15:0] instr_word = 16'h0;
  logic [7:0]  core_status_register = 8'h0, io_rdata;
  logic        instr_ready, status_write_en, instr_done, branch_taken;
  logic [4:0]  io_addr;
  logic [12:0] pc;
  logic [7:0]  fl [4] = '{8'h00, 8'h0f, 8'h04, 8'h0a};
  int          fail_count = 0, check_count = 0;
  always #5 sys_clk = ~sys_clk;
  cbs_unit i_dut (
    .sys_clk              (sys_clk),
    .arst_n               (arst_n),
    .instr_valid          (instr_valid),
    .instr_word           (instr_word),
    .next_is_two_word     (next_is_two_word),
    .core_status_register (core_status_register),
    .io_rdata             (io_rdata),
    .instr_ready          (instr_ready),
    .io_addr              (io_addr),
    .status_write_en      (status_write_en),
    .instr_done           (instr_done),
    .branch_taken         (branch_taken),
    .pc                   (pc)
  );
  cbs_io_model i_io (.io_addr(io_addr), .io_rdata(io_rdata));
  task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic tkx(input logic [3:0] op, input logic [2:0] s, input logic [7:0] f);
    case (op)
      4'h2: return f[s];
      4'h3: return !f[s];
      4'h4: return f[1];
      4'h5: return !f[1];
      4'h6, 4'h9: return f[0];
      4'h7, 4'h8: return !f[0];
      4'ha: return f[2];
      4'hb: return !f[2];
      4'hc: return !(f[2] ^ f[3]);
      4'hd: return f[2] ^ f[3];
      default: return 1'b0;
    endcase
  endfunction
  // single-cycle ops leave valid high so the next call is a true back-to-back take
  task automatic run(input logic [3:0] op, input logic [6:0] k, input logic [2:0] s,
                     input logic [7:0] f, input logic tw, input logic tk);
    logic [12:0] p0, d;
    logic        rdy;
    int          n;
    p0 = pc;
    n = 1;
    d = (op == 4'h1) ? (tw ? 13'h3 : 13'h2) : {{6{k[6]}}, k} + 13'h1;
    instr_word = {op, 2'h0, k, s};
    core_status_register = f;
    next_is_two_word = tw;
    instr_valid = 1'b1;
    @(posedge sys_clk);
    #1 rdy = instr_ready;
    if (instr_done !== 1'b1) instr_valid = 1'b0;
    while (instr_done !== 1'b1 && n < 4) begin
      @(posedge sys_clk);
      #1 n++;
    end
    cmp(pc, tk ? p0 + d : p0 + 13'h1);
    cmp({12'h0, branch_taken}, {12'h0, tk});
    cmp(13'(n), tk ? ((op == 4'h1 && tw) ? 13'h3 : 13'h2) : 13'h1);
    cmp({12'h0, status_write_en}, 13'h0);
    cmp({12'h0, rdy}, {12'h0, !tk});
  endtask
  task automatic t_flags;
    for (int op = 4; op < 14; op++)
      foreach (fl[i]) run(4'(op), 7'h05, 3'h0, fl[i], 1'b0,
                          tkx(4'(op), 3'h0, fl[i]));
    $display("t_flags done");
  endtask
  task automatic t_sbit;
    for (int s = 0; s < 8; s++) begin
      run(4'h2, 7'h7f, 3'(s), 8'ha5, 1'b0, tkx(4'h2, 3'(s), 8'ha5));
      run(4'h3, 7'h40, 3'(s), 8'ha5, 1'b0, tkx(4'h3, 3'(s), 8'ha5));
    end
    $display("t_sbit done");
  endtask
  task automatic t_skip;
    run(4'h1, 7'h01, 3'h0, 8'hff, 1'b1, 1'b1);
    run(4'h1, 7'h03, 3'h1, 8'hff, 1'b0, 1'b1);
    run(4'h1, 7'h1e, 3'h0, 8'hff, 1'b1, 1'b0);
    run(4'h0, 7'h22, 3'h7, 8'hff, 1'b0, 1'b0);
    run(4'hf, 7'h11, 3'h2, 8'hff, 1'b0, 1'b0);
    $display("t_skip done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    cmp(pc, 13'h0);
    t_flags;
    t_sbit;
    t_skip;
    end_of_test;
  end
  initial begin
    #20000 fail_count++;
    end_of_test;
  end
endmodule
